// ==== hw/rpt_timer.sv ====
/*
 Reloadable prescaled down timer: 8-bit prescaler feeding an 8-bit main
 counter, APB slave register file, underflow interrupt.
 Assumes the count-source enables (f1, f2, f8, on-chip oscillator) arrive as
 one-cycle pulses synchronous to clk_sys; apb master per the APB spec.
*/
// Contract
// - 8-bit main counter fed by 8-bit prescaler
// - Reload and counter share address; read live
// - Three-bit mode field; codes 101-111 forbidden
// - Two-bit field picks count source
// - Cutoff bit blocks count source
// - Run bit starts/stops; status flag reports counting
// - Forced halt resets run, status, counts
// - Forced halt loads prescaler with FFh
// - Underflow and edge flags set by events
// - Write 0 clears flag, 1 keeps
// - Both stages count down and reload
// - Period is (n+1)(m+1) source cycles
// - Main underflow raises interrupt request
// - Stopped write loads reload and counter
// - Running write reaches the reload register at once; the counter takes it only at its own next underflow
// - Count reads return live counter
// - Pin routing field and output pin bit
`timescale 1ns/1ps
`default_nettype none
`include "rpt_regs.svh"

module rpt_timer #(
    parameter int CNT_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              src_f1,
    input  wire logic              src_f2,
    input  wire logic              src_f8,
    input  wire logic              src_oco,
    input  wire logic              edge_event,
    output logic                   irq_underflow,
    output rpt_pkg::rpt_mode_e     mode_sel,
    output rpt_pkg::rpt_byte_t     pin_io_control,
    output logic      [1:0]        bidir_pin_route,
    output logic                   output_pin_route
);
    import rpt_pkg::*;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] idx);
        hit = (a == 12'(`RPT_ADDR_OF(idx)));
    endfunction

    logic [CNT_W-1:0] pre_cnt_ff, pre_rld_ff, main_cnt_ff, main_rld_ff;
    logic             run_ff, cstf_ff, edgf_ff, undf_ff, irq_ff;
    logic [7:0]       ioc_ff, mode_ff, route_ff;
    logic [31:0]      rdata_ff;

    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire sel_ctl = hit(paddr, `RPT_OFS_CTRL);
    wire sel_ioc = hit(paddr, `RPT_OFS_IOC);
    wire sel_mod = hit(paddr, `RPT_OFS_MODE);
    wire sel_pre = hit(paddr, `RPT_OFS_PRE);
    wire sel_mai = hit(paddr, `RPT_OFS_MAIN);
    wire sel_rte = hit(paddr, `RPT_OFS_ROUTE);
    wire mapped  = sel_ctl | sel_ioc | sel_mod | sel_pre | sel_mai | sel_rte;

    wire wr_ctl  = wr && sel_ctl;
    wire halt    = wr_ctl && pwdata[`RPT_CTRL_HALT];
    wire wr_pre  = wr && sel_pre;
    wire wr_mai  = wr && sel_mai;

    // Source mux then cutoff gate
    logic src_sel;
    always_comb begin
        case (rpt_src_e'(mode_ff[5:4]))
            RPT_SRC_F1:  src_sel = src_f1;
            RPT_SRC_F8:  src_sel = src_f8;
            RPT_SRC_OCO: src_sel = src_oco;
            RPT_SRC_F2:  src_sel = src_f2;
            default:     src_sel = 1'b0;
        endcase
    end
    wire src_tick = src_sel && !mode_ff[`RPT_MODE_CUTOFF];

    // Counting uses the synchronised status flag, not the raw run bit
    wire cnt_tick = src_tick && cstf_ff && !halt;
    wire pre_unf  = cnt_tick && (pre_cnt_ff == '0);
    wire main_unf = pre_unf && (main_cnt_ff == '0);

    // Prescaler: reload on underflow picks up any value written meanwhile
    wire [CNT_W-1:0] nxt_pre_cnt =
        halt                 ? CNT_W'(`RPT_RST_CNT) :
        (wr_pre && !cstf_ff) ? pwdata[CNT_W-1:0] :
        pre_unf              ? pre_rld_ff :
        cnt_tick             ? pre_cnt_ff - 1'b1 : pre_cnt_ff;
    wire [CNT_W-1:0] nxt_main_cnt =
        halt                 ? CNT_W'(`RPT_RST_CNT) :
        (wr_mai && !cstf_ff) ? pwdata[CNT_W-1:0] :
        main_unf             ? main_rld_ff :
        pre_unf              ? main_cnt_ff - 1'b1 : main_cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (!rstn || halt) begin
            pre_cnt_ff  <= CNT_W'(`RPT_RST_CNT);
            main_cnt_ff <= CNT_W'(`RPT_RST_CNT);
        end else begin
            pre_cnt_ff  <= nxt_pre_cnt;
            main_cnt_ff <= nxt_main_cnt;
        end
    end

    // Reload registers: written immediately, counter follows later if running
    always_ff @(posedge clk_sys) begin
        if (!rstn || halt) begin
            pre_rld_ff  <= CNT_W'(`RPT_RST_CNT);
            main_rld_ff <= CNT_W'(`RPT_RST_CNT);
        end else begin
            if (wr_pre)
                pre_rld_ff  <= pwdata[CNT_W-1:0];
            if (wr_mai)
                main_rld_ff <= pwdata[CNT_W-1:0];
        end
    end

    // Run request and status
    wire nxt_run  = wr_ctl ? pwdata[`RPT_CTRL_RUN] : run_ff;
    // Status changes only on a source event or a forced halt, so stop/start align to it
    wire nxt_cstf = src_tick ? run_ff : cstf_ff;
    // Set beats a simultaneous clear
    wire nxt_undf = main_unf || (undf_ff && !(wr_ctl && !pwdata[`RPT_CTRL_UNDF]));
    wire edge_set = edge_event && cstf_ff &&
                    (mode_ff[2:0] == RPT_MODE_WIDTH || mode_ff[2:0] == RPT_MODE_PERIOD);
    wire nxt_edgf = edge_set || (edgf_ff && !(wr_ctl && !pwdata[`RPT_CTRL_EDGF]));

    always_ff @(posedge clk_sys) begin
        if (!rstn || halt) begin
            run_ff  <= 1'b0;
            cstf_ff <= 1'b0;
        end else begin
            run_ff  <= nxt_run;
            cstf_ff <= nxt_cstf;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            undf_ff <= 1'b0;
            edgf_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end else begin
            undf_ff <= nxt_undf;
            edgf_ff <= nxt_edgf;
            irq_ff  <= main_unf;
        end
    end

    // Mode written while stopped is software's duty; hardware accepts any time
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ioc_ff   <= `RPT_RST_REG;
            mode_ff  <= `RPT_RST_REG;
            route_ff <= `RPT_RST_REG;
        end else begin
            if (wr && sel_ioc)
                ioc_ff   <= pwdata[7:0];
            if (wr && sel_mod)
                mode_ff  <= pwdata[7:0] & `RPT_MODE_WMASK;
            if (wr && sel_rte)
                route_ff <= pwdata[7:0] & `RPT_ROUTE_WMASK;
        end
    end

    wire [7:0] ctl_rd = {2'b00, undf_ff, edgf_ff, 1'b0, 1'b0, cstf_ff, run_ff} & `RPT_CTRL_RMASK;
    wire [7:0] rd_byte =
        sel_ctl ? ctl_rd :
        sel_ioc ? ioc_ff :
        sel_mod ? mode_ff :
        sel_pre ? 8'(pre_cnt_ff) :
        sel_mai ? 8'(main_cnt_ff) :
        sel_rte ? route_ff : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!rstn)
            rdata_ff <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            rdata_ff <= {24'h00_0000, rd_byte};
    end

    assign prdata           = rdata_ff;
    assign pready           = 1'b1;
    assign pslverr          = acc && !mapped;
    assign irq_underflow    = irq_ff;
    assign mode_sel         = rpt_mode_e'(mode_ff[2:0]);
    assign pin_io_control   = ioc_ff;
    assign bidir_pin_route  = route_ff[1:0];
    assign output_pin_route = route_ff[`RPT_ROUTE_OUT];

    property p_halt_clears;
        @(posedge clk_sys) disable iff (!rstn)
        halt |=> (!run_ff && !cstf_ff && pre_cnt_ff == 8'hff && main_cnt_ff == 8'hff);
    endproperty
    a_halt_clears: assert property (p_halt_clears) else $error("halt did not reset");

    property p_unf_irq;
        @(posedge clk_sys) disable iff (!rstn)
        main_unf |=> irq_underflow && undf_ff;
    endproperty
    a_unf_irq: assert property (p_unf_irq) else $error("underflow missed irq");

    property p_pre_reload;
        @(posedge clk_sys) disable iff (!rstn)
        (pre_unf && !wr_pre) |=> pre_cnt_ff == $past(pre_rld_ff);
    endproperty
    a_pre_reload: assert property (p_pre_reload) else $error("prescaler reload wrong");

    property p_dec;
        @(posedge clk_sys) disable iff (!rstn)
        (cnt_tick && !pre_unf && !wr_pre) |=> pre_cnt_ff == $past(pre_cnt_ff) - 8'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("prescaler not decremented");

    property p_cut;
        @(posedge clk_sys) disable iff (!rstn)
        (mode_ff[7] && !halt && !wr_pre) |=> $stable(pre_cnt_ff);
    endproperty
    a_cut: assert property (p_cut) else $error("count with source cut");

    property p_stop_wr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_mai && !cstf_ff && !halt) |=> main_cnt_ff == $past(pwdata[7:0]) && main_rld_ff == main_cnt_ff;
    endproperty
    a_stop_wr: assert property (p_stop_wr) else $error("stopped write not loaded");

    property p_run_wr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_mai && cstf_ff && !pre_unf && !halt) |=> main_cnt_ff == $past(main_cnt_ff);
    endproperty
    a_run_wr: assert property (p_run_wr) else $error("running write hit counter");

    property p_clr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_ctl && !pwdata[5] && !main_unf) |=> !undf_ff;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");

    property p_keep;
        @(posedge clk_sys) disable iff (!rstn)
        (undf_ff && wr_ctl && pwdata[5]) |=> undf_ff;
    endproperty
    a_keep: assert property (p_keep) else $error("flag lost on write 1");

    property p_cstf;
        @(posedge clk_sys) disable iff (!rstn)
        (src_tick && !halt) |=> cstf_ff == $past(run_ff);
    endproperty
    a_cstf: assert property (p_cstf) else $error("status not following run");

    property p_run_bit;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_ctl && !halt) |=> run_ff == $past(pwdata[0]);
    endproperty
    a_run_bit: assert property (p_run_bit) else $error("run bit not written");

    property p_halt_pre;
        @(posedge clk_sys) disable iff (!rstn)
        halt |=> pre_cnt_ff == 8'hff && pre_rld_ff == 8'hff;
    endproperty
    a_halt_pre: assert property (p_halt_pre) else $error("halt left prescaler");

    property p_rld_wr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_pre && !halt) |=> pre_rld_ff == $past(pwdata[7:0]);
    endproperty
    a_rld_wr: assert property (p_rld_wr) else $error("reload not written");

    property p_edge_set;
        @(posedge clk_sys) disable iff (!rstn)
        edge_set |=> edgf_ff;
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

    property p_edge_clr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_ctl && !pwdata[4] && !edge_set) |=> !edgf_ff;
    endproperty
    a_edge_clr: assert property (p_edge_clr) else $error("edge flag not cleared");

    property p_main_reload;
        @(posedge clk_sys) disable iff (!rstn)
        (main_unf && !wr_mai) |=> main_cnt_ff == $past(main_rld_ff);
    endproperty
    a_main_reload: assert property (p_main_reload) else $error("main reload wrong");

    property p_main_dec;
        @(posedge clk_sys) disable iff (!rstn)
        (pre_unf && !main_unf && !wr_mai) |=> main_cnt_ff == $past(main_cnt_ff) - 8'h01;
    endproperty
    a_main_dec: assert property (p_main_dec) else $error("main not decremented");

    property p_idle;
        @(posedge clk_sys) disable iff (!rstn)
        (!cnt_tick && !wr_pre && !halt) |=> $stable(pre_cnt_ff);
    endproperty
    a_idle: assert property (p_idle) else $error("prescaler moved without tick");

    property p_pre_run_wr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_pre && cstf_ff && !cnt_tick) |=> pre_cnt_ff == $past(pre_cnt_ff);
    endproperty
    a_pre_run_wr: assert property (p_pre_run_wr) else $error("running write hit prescaler");

    property p_pre_stop_wr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr_pre && !cstf_ff) |=> pre_cnt_ff == $past(pwdata[7:0]);
    endproperty
    a_pre_stop_wr: assert property (p_pre_stop_wr) else $error("stopped prescaler write lost");

    property p_irq_src;
        @(posedge clk_sys) disable iff (!rstn)
        irq_underflow |-> $past(main_unf);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq without underflow");

    property p_rd_pre;
        @(posedge clk_sys) disable iff (!rstn)
        (psel && !penable && !pwrite && sel_pre) |=> prdata[7:0] == $past(pre_cnt_ff);
    endproperty
    a_rd_pre: assert property (p_rd_pre) else $error("prescaler read not live");

    property p_mode_wr;
        @(posedge clk_sys) disable iff (!rstn)
        (wr && sel_mod) |=> mode_ff[2:0] == $past(pwdata[2:0]);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode field not written");

endmodule // rpt_timer
`default_nettype wire

// ==== pkg/rpt_pkg.sv ====
/*
 Types shared by the reloadable prescaled down timer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rpt_pkg;
    typedef enum logic [2:0] {
        RPT_MODE_TIMER  = 3'h0,
        RPT_MODE_PULSE  = 3'h1,
        RPT_MODE_EVENT  = 3'h2,
        RPT_MODE_WIDTH  = 3'h3,
        RPT_MODE_PERIOD = 3'h4
    } rpt_mode_e;
    typedef enum logic [1:0] {
        RPT_SRC_F1  = 2'h0,
        RPT_SRC_F8  = 2'h1,
        RPT_SRC_OCO = 2'h2,
        RPT_SRC_F2  = 2'h3
    } rpt_src_e;
    typedef logic [7:0] rpt_byte_t;
endpackage
`default_nettype wire

// ==== pkg/rpt_regs.svh ====
/*
 Register offsets, field positions, reset values and masks of the
 reloadable prescaled down timer. Assumes inclusion by bare name.
*/
`ifndef RPT_REGS_SVH
`define RPT_REGS_SVH

`define RPT_OFS_CTRL        12'h100
`define RPT_OFS_IOC         12'h101
`define RPT_OFS_MODE        12'h102
`define RPT_OFS_PRE         12'h103
`define RPT_OFS_MAIN        12'h104
`define RPT_OFS_ROUTE       12'h105
`define RPT_ADDR_OF(i)      ({(i), 2'b00})

`define RPT_CTRL_RUN        0
`define RPT_CTRL_CSTF       1
`define RPT_CTRL_HALT       2
`define RPT_CTRL_EDGF       4
`define RPT_CTRL_UNDF       5
`define RPT_MODE_CUTOFF     7
`define RPT_ROUTE_OUT       3

`define RPT_RST_REG         8'h00
`define RPT_RST_CNT         8'hff
`define RPT_CTRL_RMASK      8'h33
`define RPT_MODE_WMASK      8'hb7
`define RPT_ROUTE_WMASK     8'h1f

`endif

// ==== verification/tb_top.sv ====
/*
 Self-checking bench for the reloadable prescaled down timer: APB tasks,
 queued read notes, count-source pulse generator, period and flag checks.
 Assumes rpt_pkg and rpt_regs.svh are visible; assertions live in the design.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rpt_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module tb_top;
    import rpt_pkg::*;
    localparam logic [11:0] A_CTRL  = 12'(`RPT_ADDR_OF(`RPT_OFS_CTRL));
    localparam logic [11:0] A_IOC   = 12'(`RPT_ADDR_OF(`RPT_OFS_IOC));
    localparam logic [11:0] A_MODE  = 12'(`RPT_ADDR_OF(`RPT_OFS_MODE));
    localparam logic [11:0] A_PRE   = 12'(`RPT_ADDR_OF(`RPT_OFS_PRE));
    localparam logic [11:0] A_MAIN  = 12'(`RPT_ADDR_OF(`RPT_OFS_MAIN));
    localparam logic [11:0] A_ROUTE = 12'(`RPT_ADDR_OF(`RPT_OFS_ROUTE));
    logic        clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, seed = 32'h0000_0057, v;
    logic        pready, pslverr, irq_underflow, output_pin_route;
    logic        src_f1 = 0, src_f2 = 0, src_f8 = 0, src_oco = 0, edge_event = 0, edge_on = 0;
    rpt_mode_e   mode_sel;
    rpt_byte_t   pin_io_control;
    logic [1:0]  bidir_pin_route;
    logic [7:0]  div = '0, n, m;
    logic [32:0] notes[$], exp_n;
    int          bad_count = 0, n_compared = 0, irq_n = 0, c, i0;
    int          dv[4] = '{1, 8, 4, 2};

    rpt_timer dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_f1(src_f1), .src_f2(src_f2), .src_f8(src_f8), .src_oco(src_oco), .edge_event(edge_event),
        .irq_underflow(irq_underflow), .mode_sel(mode_sel), .pin_io_control(pin_io_control),
        .bidir_pin_route(bidir_pin_route), .output_pin_route(output_pin_route));

    always #50 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Fixed source ratios so periods are exact: f1 every, f2 /2, oco /4, f8 /8
    always @(posedge clk_sys) begin
        div        <= div + 8'h01;
        src_f1     <= 1'b1;
        src_f2     <= div[0];
        src_oco    <= (div[1:0] == 2'h3);
        src_f8     <= (div[2:0] == 3'h7);
        edge_event <= edge_on;
        if (irq_underflow === 1'b1) irq_n <= irq_n + 1;
        if (psel && penable && pready && !pwrite) begin
            exp_n = notes.pop_front();
            `CHK({pslverr, prdata}, exp_n)
        end
    end

    // Request held from setup until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        if (!w) notes.push_back(e);
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, '0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {9'h0, 16'h0, d});
    endtask
    // Edges until the next underflow pulse; limit keeps a dead timer from hanging
    task automatic wait_irq(output int cnt);
        cnt = 0;
        do begin @(posedge clk_sys); cnt++; end while (irq_underflow !== 1'b1 && cnt < 20000);
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(A_CTRL, 8'h00);
        rd(A_IOC, 8'h00);
        rd(A_MODE, 8'h00);
        rd(A_PRE, 8'hff);
        rd(A_MAIN, 8'hff);
        apb(1'b0, 12'h7f0, 8'h00, {1'b1, 32'h0});
        v = rnd();
        wr(A_ROUTE, {4'h0, v[3], 2'h0, v[4]});
        rd(A_ROUTE, {4'h0, v[3], 2'h0, v[4]});
        `CHK(bidir_pin_route, {1'b0, v[4]})
        `CHK(output_pin_route, v[3])
        v = rnd();
        wr(A_IOC, v[7:0]);
        rd(A_IOC, v[7:0]);
        `CHK(pin_io_control, v[7:0])
        wr(A_IOC, 8'h00);
        for (int k = 0; k < 5; k++) begin
            wr(A_MODE, 8'(k));
            rd(A_MODE, 8'(k));
            `CHK(mode_sel, rpt_mode_e'(k))
        end
        v = rnd();
        wr(A_PRE, v[7:0]);
        wr(A_MAIN, v[15:8]);
        rd(A_PRE, v[7:0]);
        rd(A_MAIN, v[15:8]);
        // Cut-off source: run requested but nothing may count
        wr(A_MODE, 8'h80);
        wr(A_PRE, 8'h00);
        wr(A_MAIN, 8'h00);
        i0 = irq_n;
        wr(A_CTRL, 8'h01);
        repeat (40) @(posedge clk_sys);
        rd(A_CTRL, 8'h01);
        `CHK(irq_n, i0)
        wr(A_CTRL, 8'h00);
        for (int s = 0; s < 4; s++) begin
            v = rnd();
            n = {6'h0, v[1:0]};
            m = {6'h0, v[3:2]};
            wr(A_MODE, {2'h0, 2'(s), 4'h0});
            wr(A_PRE, n);
            wr(A_MAIN, m);
            wr(A_CTRL, 8'h01);
            wait_irq(c);
            wait_irq(c);
            `CHK(c, (n + 1) * (m + 1) * dv[s])
            wr(A_CTRL, 8'h00);
            repeat (40) @(posedge clk_sys);
        end
        wr(A_MODE, 8'h10);
        wr(A_CTRL, 8'h00);
        wr(A_PRE, 8'hff);
        wr(A_MAIN, 8'h03);
        wr(A_CTRL, 8'h01);
        repeat (20) @(posedge clk_sys);
        wr(A_MAIN, 8'h01);
        rd(A_MAIN, 8'h03);
        wait_irq(c);
        wait_irq(c);
        `CHK(c, 4096)
        rd(A_CTRL, 8'h23);
        wr(A_CTRL, 8'h21);
        rd(A_CTRL, 8'h23);
        wr(A_CTRL, 8'h01);
        rd(A_CTRL, 8'h03);
        wr(A_CTRL, 8'h05);
        rd(A_CTRL, 8'h00);
        rd(A_PRE, 8'hff);
        rd(A_MAIN, 8'hff);
        // Width measurement: edge sets the edge flag, writing 0 clears it
        wr(A_MODE, 8'h03);
        wr(A_MAIN, 8'hff);
        wr(A_CTRL, 8'h31);
        repeat (4) @(posedge clk_sys);
        edge_on <= 1'b1;
        repeat (4) @(posedge clk_sys);
        edge_on <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(A_CTRL, 8'h13);
        wr(A_CTRL, 8'h21);
        rd(A_CTRL, 8'h03);
        wr(A_CTRL, 8'h04);
        wr(A_MODE, 8'h00);
        rd(A_CTRL, 8'h00);
        repeat (4) @(posedge clk_sys);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
